/* File: common/dbu_map.svh */
// Register offsets, field positions, reset values and timing counts of the debug port
`ifndef DBU_MAP_SVH
`define DBU_MAP_SVH

// Core clock and line rate
`define DBU_CLK_HZ      100000000
`define DBU_BAUD_RST    115200
`define DBU_OVS         16
// Clocks per oversampling tick, rounded down
`define DBU_DIV_RST     16'(`DBU_CLK_HZ / (`DBU_BAUD_RST * `DBU_OVS))
// Oversampling tick index of a bit centre and of a bit end
`define DBU_MID_TICK    4'h7
`define DBU_END_TICK    4'hF

// Register byte offsets
`define DBU_A_DATA      5'h00
`define DBU_A_CTRL      5'h04
`define DBU_A_DIV       5'h08
`define DBU_A_STAT      5'h0C
`define DBU_A_IRQ       5'h10
`define DBU_A_ICLR      5'h14
`define DBU_A_IEN       5'h18

// Format control fields
`define DBU_CTRL_SEVEN  0
`define DBU_CTRL_PAREN  1
`define DBU_CTRL_ODD    2
`define DBU_CTRL_STOP2  3
`define DBU_CTRL_RST    4'h0

// Event bits of status, clear and enable registers
`define DBU_IRQ_RXAV    0
`define DBU_IRQ_OVR     1
`define DBU_IRQ_PAR     2
`define DBU_IRQ_FRM     3
`define DBU_IEN_RST     4'h0

// Status register fields
`define DBU_STAT_TXFULL 3
`define DBU_STAT_TXEMPT 4

`endif

/* File: common/dbu_pkg.sv */
// Types shared by the debug serial port modules
package dbu_pkg;

  // Receiver states, one-hot
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_PAR   = 5'h08,
    RX_STOP  = 5'h10
  } dbu_rx_state_type;

  // Transmitter states, one-hot
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } dbu_tx_state_type;

  // Four-entry character store
  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [1:0]      wptr;
    logic [1:0]      rptr;
    logic [2:0]      cnt;
  } dbu_fifo_type;

  // Oversampling divider
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } dbu_baud_type;

  // Whole state of the port
  typedef struct packed {
    logic [3:0]       ctrl;
    logic [15:0]      div;
    logic [3:0]       ien;
    logic [3:0]       ists;
    logic [7:0]       rdata;
    logic [2:0]       rx_sync;
    dbu_rx_state_type rx_st;
    logic [3:0]       rx_tc;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_par;
    dbu_tx_state_type tx_st;
    logic [3:0]       tx_tc;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic             tx_par;
    logic             tx_stop2;
    logic             txd;
  } dbu_state_type;

endpackage : dbu_pkg

/* File: src/dbu_baud.sv */
// Oversampling tick divider, one pulse every div clocks
`timescale 1ns/10ps
module dbu_baud
  import dbu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] div,
  output logic             tick
);

  dbu_baud_type r_ff;     // Divider state
  dbu_baud_type nxt_r;    // Next divider state

  assign tick = r_ff.tick;

  // Count up; a divisor of zero or one ticks every clock
  always_comb begin
    nxt_r = r_ff;
    if (r_ff.cnt + 16'h0001 >= div) begin
      nxt_r.cnt  = 16'h0000;
      nxt_r.tick = 1'b1;
    end else begin
      nxt_r.cnt  = r_ff.cnt + 16'h0001;
      nxt_r.tick = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule : dbu_baud

/* File: src/dbu_fifo.sv */
// Four-deep, eight-bit character store with registered entries
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_fifo
  import dbu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       push,
  input  wire logic [7:0] wdata,
  input  wire logic       pop,
  output logic      [7:0] rdata,
  output logic      [2:0] count,
  output logic            full,
  output logic            empty
);

  dbu_fifo_type r_ff;      // Registered store
  dbu_fifo_type nxt_r;     // Next store

  // Flags and head word straight from the registers
  assign full  = (r_ff.cnt == 3'h4);
  assign empty = (r_ff.cnt == 3'h0);
  assign count = r_ff.cnt;
  assign rdata = r_ff.mem[r_ff.rptr];

  // Push and pop; callers never push when full nor pop when empty
  always_comb begin
    nxt_r = r_ff;
    if (push) begin
      nxt_r.mem[r_ff.wptr] = wdata;
      nxt_r.wptr           = r_ff.wptr + 2'h1;
    end
    if (pop) begin
      nxt_r.rptr = r_ff.rptr + 2'h1;
    end
    // Simultaneous push and pop leaves the count alone
    case ({push, pop})
      2'b10:   nxt_r.cnt = r_ff.cnt + 3'h1;
      2'b01:   nxt_r.cnt = r_ff.cnt - 3'h1;
      default: nxt_r.cnt = r_ff.cnt;
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule : dbu_fifo

/* File: src/dbu_uart.sv */
// Debug serial port: registers, receiver, transmitter and interrupt
//
// Notes on behaviour
// - Reset format 115200, 8N1, no flow control
// - Receive and transmit stores, four by eight
// - Status shows characters waiting for reading
// - Receive errors latched in readable status bits
// - Interrupt from receive and error status bits
// - One receive and one transmit line only
// - Seven bits, odd parity, two stops selectable
// - Idle, start, data, parity, stops, then idle
// - Pins shared with card and slave lines
// - Acts as terminal equipment role end
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_uart
  import dbu_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic [4:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       RXD,
  output logic            TXD,
  output logic            IRQ
);

  // Reset image of the whole state
  localparam dbu_state_type RST_VAL = '{
    ctrl:     `DBU_CTRL_RST,
    div:      `DBU_DIV_RST,
    ien:      `DBU_IEN_RST,
    ists:     4'h0,
    rdata:    8'h00,
    rx_sync:  3'h7,
    rx_st:    RX_IDLE,
    rx_tc:    4'h0,
    rx_bit:   3'h0,
    rx_sh:    8'h00,
    rx_par:   1'b0,
    tx_st:    TX_IDLE,
    tx_tc:    4'h0,
    tx_bit:   3'h0,
    tx_sh:    8'h00,
    tx_par:   1'b0,
    tx_stop2: 1'b0,
    txd:      1'b1
  };

  dbu_state_type r_ff;        // Registered state
  dbu_state_type nxt_r;       // Next state

  logic       tick;           // Sixteen-times bit rate pulse
  logic       rx_push;        // Finished character into receive store
  logic [7:0] rx_din;         // Finished character
  logic       rx_pop;         // Software takes a character
  logic [7:0] rx_head;        // Oldest waiting character
  logic [2:0] rx_cnt;         // Characters waiting
  logic       rx_full;        // Receive store full
  logic       rx_empty;       // Receive store empty
  logic       tx_push;        // Software queues a character
  logic       tx_pop;         // Transmitter takes a character
  logic [7:0] tx_head;        // Next character to send
  logic       tx_full;        // Transmit store full
  logic       tx_empty;       // Transmit store empty
  logic       rx_s;           // Synchronised receive level
  logic       seven;          // Seven data bits selected
  logic       paren;          // Parity bit present
  logic       odd;            // Odd parity selected
  logic [2:0] last_bit;       // Index of the final data bit
  logic [3:0] set_ev;         // Events raised this cycle
  logic [3:0] clr_ev;         // Software clear mask this cycle

  // Parity of a character of the chosen width
  function automatic logic fmt_par(input logic [7:0] d, input logic sev, input logic o);
    fmt_par = (sev ? ^d[6:0] : ^d) ^ o;
  endfunction : fmt_par

  // Oversampling tick from the programmed divisor
  dbu_baud u_baud (
    .clk  (CLK),
    .rst  (RST),
    .div  (r_ff.div),
    .tick (tick)
  );

  // Received characters wait here for software
  dbu_fifo u_rx_fifo (
    .clk   (CLK),
    .rst   (RST),
    .push  (rx_push),
    .wdata (rx_din),
    .pop   (rx_pop),
    .rdata (rx_head),
    .count (rx_cnt),
    .full  (rx_full),
    .empty (rx_empty)
  );

  // Queued characters wait here for the line
  dbu_fifo u_tx_fifo (
    .clk   (CLK),
    .rst   (RST),
    .push  (tx_push),
    .wdata (WDATA),
    .pop   (tx_pop),
    .rdata (tx_head),
    .count (),
    .full  (tx_full),
    .empty (tx_empty)
  );

  // Outputs; the pad muxing toward the card and slave lines sits outside
  assign TXD   = r_ff.txd;
  assign RDATA = r_ff.rdata;
  assign IRQ   = |(r_ff.ists & r_ff.ien);

  // Format fields and the synchronised line
  assign rx_s     = r_ff.rx_sync[1];
  assign seven    = r_ff.ctrl[`DBU_CTRL_SEVEN];
  assign paren    = r_ff.ctrl[`DBU_CTRL_PAREN];
  assign odd      = r_ff.ctrl[`DBU_CTRL_ODD];
  assign last_bit = seven ? 3'h6 : 3'h7;

  // Whole next-state logic
  always_comb begin
    nxt_r   = r_ff;
    rx_push = 1'b0;
    rx_din  = seven ? {1'b0, r_ff.rx_sh[7:1]} : r_ff.rx_sh;
    tx_pop  = 1'b0;
    set_ev  = 4'h0;
    clr_ev  = 4'h0;

    // Two flops on the pin, third one only for edge finding
    nxt_r.rx_sync = {r_ff.rx_sync[1:0], RXD};

    // Bus side: writes to a full transmit store are dropped
    tx_push = WR && (ADDR == `DBU_A_DATA) && !tx_full;
    rx_pop  = RD && (ADDR == `DBU_A_DATA) && !rx_empty;
    if (WR) begin
      case (ADDR)
        `DBU_A_CTRL: nxt_r.ctrl = WDATA[3:0];
        `DBU_A_DIV:  nxt_r.div  = {8'h00, WDATA};
        `DBU_A_ICLR: clr_ev     = WDATA[3:0];
        `DBU_A_IEN:  nxt_r.ien  = WDATA[3:0];
        default:     nxt_r.ctrl = r_ff.ctrl;          // Others ignore writes
      endcase
    end

    // Read data for the cycle after the strobe; unmapped reads zero
    if (RD) begin
      case (ADDR)
        `DBU_A_DATA: nxt_r.rdata = rx_head;
        `DBU_A_CTRL: nxt_r.rdata = {4'h0, r_ff.ctrl};
        `DBU_A_DIV:  nxt_r.rdata = r_ff.div[7:0];
        `DBU_A_STAT: nxt_r.rdata = {3'h0, tx_empty, tx_full, rx_cnt};
        `DBU_A_IRQ:  nxt_r.rdata = {4'h0, r_ff.ists};
        `DBU_A_IEN:  nxt_r.rdata = {4'h0, r_ff.ien};
        default:     nxt_r.rdata = 8'h00;
      endcase
    end else begin
      nxt_r.rdata = 8'h00;
    end

    // Receiver: hunt for a falling edge, then sample mid-bit
    case (r_ff.rx_st)
      RX_IDLE: begin
        if (r_ff.rx_sync[2] && !rx_s) begin
          nxt_r.rx_st  = RX_START;
          nxt_r.rx_tc  = 4'h0;
          nxt_r.rx_par = 1'b0;
        end
      end
      RX_START: begin
        if (tick) begin
          if (r_ff.rx_tc == `DBU_MID_TICK) begin
            // A short glitch is not a start bit
            nxt_r.rx_st  = rx_s ? RX_IDLE : RX_DATA;
            nxt_r.rx_tc  = 4'h0;
            nxt_r.rx_bit = 3'h0;
          end else begin
            nxt_r.rx_tc = r_ff.rx_tc + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          if (r_ff.rx_tc == `DBU_END_TICK) begin
            // Least significant bit first
            nxt_r.rx_tc  = 4'h0;
            nxt_r.rx_sh  = {rx_s, r_ff.rx_sh[7:1]};
            nxt_r.rx_par = r_ff.rx_par ^ rx_s;
            if (r_ff.rx_bit == last_bit) begin
              nxt_r.rx_st = paren ? RX_PAR : RX_STOP;
            end else begin
              nxt_r.rx_bit = r_ff.rx_bit + 3'h1;
            end
          end else begin
            nxt_r.rx_tc = r_ff.rx_tc + 4'h1;
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          if (r_ff.rx_tc == `DBU_END_TICK) begin
            nxt_r.rx_tc  = 4'h0;
            nxt_r.rx_par = r_ff.rx_par ^ rx_s;
            nxt_r.rx_st  = RX_STOP;
          end else begin
            nxt_r.rx_tc = r_ff.rx_tc + 4'h1;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          if (r_ff.rx_tc == `DBU_END_TICK) begin
            // Only the first stop is checked, so back-to-back frames resync early
            nxt_r.rx_st = RX_IDLE;
            nxt_r.rx_tc = 4'h0;
            if (rx_full) begin
              set_ev[`DBU_IRQ_OVR] = 1'b1;
            end else begin
              rx_push              = 1'b1;
              set_ev[`DBU_IRQ_RXAV] = 1'b1;
            end
            set_ev[`DBU_IRQ_FRM] = !rx_s;
            set_ev[`DBU_IRQ_PAR] = paren && (r_ff.rx_par != odd);
          end else begin
            nxt_r.rx_tc = r_ff.rx_tc + 4'h1;
          end
        end
      end
      default: nxt_r.rx_st = RX_IDLE;
    endcase

    // Transmitter: sixteen ticks per bit, line idles high
    case (r_ff.tx_st)
      TX_IDLE: begin
        nxt_r.txd = 1'b1;
        if (!tx_empty) begin
          tx_pop       = 1'b1;
          nxt_r.tx_sh  = tx_head;
          nxt_r.tx_par = fmt_par(tx_head, seven, odd);
          nxt_r.tx_tc  = 4'h0;
          nxt_r.tx_st  = TX_START;
          nxt_r.txd    = 1'b0;
        end
      end
      TX_START: begin
        if (tick) begin
          if (r_ff.tx_tc == `DBU_END_TICK) begin
            nxt_r.tx_tc  = 4'h0;
            nxt_r.tx_bit = 3'h0;
            nxt_r.tx_st  = TX_DATA;
            nxt_r.txd    = r_ff.tx_sh[0];
          end else begin
            nxt_r.tx_tc = r_ff.tx_tc + 4'h1;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          if (r_ff.tx_tc == `DBU_END_TICK) begin
            nxt_r.tx_tc = 4'h0;
            if (r_ff.tx_bit == last_bit) begin
              // Stop count is taken here, so a late change waits a frame
              nxt_r.tx_stop2 = r_ff.ctrl[`DBU_CTRL_STOP2];
              nxt_r.tx_st    = paren ? TX_PAR : TX_STOP;
              nxt_r.txd      = paren ? r_ff.tx_par : 1'b1;
            end else begin
              nxt_r.tx_bit = r_ff.tx_bit + 3'h1;
              nxt_r.tx_sh  = {1'b0, r_ff.tx_sh[7:1]};
              nxt_r.txd    = r_ff.tx_sh[1];
            end
          end else begin
            nxt_r.tx_tc = r_ff.tx_tc + 4'h1;
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          if (r_ff.tx_tc == `DBU_END_TICK) begin
            nxt_r.tx_tc = 4'h0;
            nxt_r.tx_st = TX_STOP;
            nxt_r.txd   = 1'b1;
          end else begin
            nxt_r.tx_tc = r_ff.tx_tc + 4'h1;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          if (r_ff.tx_tc == `DBU_END_TICK) begin
            nxt_r.tx_tc = 4'h0;
            if (r_ff.tx_stop2) begin
              nxt_r.tx_stop2 = 1'b0;
            end else begin
              nxt_r.tx_st = TX_IDLE;
            end
          end else begin
            nxt_r.tx_tc = r_ff.tx_tc + 4'h1;
          end
        end
      end
      default: nxt_r.tx_st = TX_IDLE;
    endcase

    // Sticky events: a new event beats a clear in the same cycle
    nxt_r.ists = (r_ff.ists & ~clr_ev) | set_ev;
  end

  // State register; reset gives the default 8N1 format and divisor
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r_ff <= RST_VAL;
    end else begin
      r_ff <= nxt_r;
    end
  end

endmodule : dbu_uart

/* File: tb/dbu_term.sv */
// Terminal model: frames characters onto the receive pin, decodes the transmit pin
`timescale 1ns/10ps
module dbu_term #(
  parameter int BITCLK = 16  // Clocks per bit, divider of one
) (
  input  wire logic       clk,
  input  wire logic [3:0] fmt,      // Seven, parity, odd, two stops
  input  wire logic       line_in,  // Port transmit pin
  output logic            line_out  // Port receive pin
);
  logic [7:0] got_q [$];  // Decoded characters, oldest first
  int         bad_cnt;    // Parity or stop faults seen on the wire

  // Parity bit for a character in the given format
  function automatic logic par_of(input logic [3:0] f, input logic [7:0] v);
    return (f[0] ? ^v[6:0] : ^v) ^ f[2];
  endfunction : par_of

  // Terminal line idles high
  initial line_out = 1'b1;

  // One frame, called right after a clock edge; faults only on request
  task automatic send(input logic [7:0] v, input logic bad_par, input logic bad_stop);
    line_out <= 1'b0;
    repeat (BITCLK) @(posedge clk);
    for (int i = 0; i < (fmt[0] ? 7 : 8); i++) begin
      line_out <= v[i];
      repeat (BITCLK) @(posedge clk);
    end
    if (fmt[1]) begin
      line_out <= par_of(fmt, v) ^ bad_par;
      repeat (BITCLK) @(posedge clk);
    end
    line_out <= ~bad_stop;
    repeat (fmt[3] ? 2 * BITCLK : BITCLK) @(posedge clk);
    // Only a broken stop needs lifting; one idle clock keeps the next start apart
    if (bad_stop) begin
      line_out <= 1'b1;
      @(posedge clk);
    end
  endtask : send

  // Decoder samples each bit at its centre
  initial begin : rx_p
    logic [7:0] v;
    bad_cnt = 0;
    forever begin
      @(posedge clk);
      if (line_in === 1'b0) begin
        v = 8'h00;
        repeat (BITCLK / 2) @(posedge clk);
        for (int i = 0; i < (fmt[0] ? 7 : 8); i++) begin
          repeat (BITCLK) @(posedge clk);
          v[i] = line_in;
        end
        repeat (BITCLK) @(posedge clk);
        // Parity slot only when enabled
        if (fmt[1] && line_in !== par_of(fmt, v)) bad_cnt++;
        if (fmt[1]) repeat (BITCLK) @(posedge clk);
        // First stop bit must be high
        if (line_in !== 1'b1) bad_cnt++;
        got_q.push_back(v);
      end
    end
  end
endmodule : dbu_term

/* File: tb/dbu_uart_sva.sv */
// Concurrent checks on the debug serial port pins and register bus
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_uart_sva
  import dbu_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST,
  input wire logic [4:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       RXD,
  input wire logic       TXD,
  input wire logic       IRQ
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Pins leave reset idle and quiet
  a_idle_after_reset: assert property ($fell(RST) |-> TXD && !IRQ && RDATA == 8'h00)
    else $error("outputs not idle after reset");
  // Read data stands only in the answer cycle
  a_rdata_idle_zero: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  // Status never claims more than four waiting
  a_stat_shape: assert property ($past(RD) && $past(ADDR) == `DBU_A_STAT
    |-> RDATA[7:5] == 3'h0 && RDATA[2:0] <= 3'h4)
    else $error("status count out of range");
  // Unmapped place reads zero
  a_unmapped_zero: assert property ($past(RD) && $past(ADDR) == 5'h1C |-> RDATA == 8'h00)
    else $error("unmapped read not zero");
  // Interrupt drops once every source is masked
  a_mask_drops_irq: assert property (WR && ADDR == `DBU_A_IEN && WDATA[3:0] == 4'h0 |=> !IRQ)
    else $error("interrupt high with all sources masked");
  // Enable register reads back what was written
  a_ien_readback: assert property ((WR && ADDR == `DBU_A_IEN)
    ##1 (RD && ADDR == `DBU_A_IEN) |=> RDATA[3:0] == 4'($past(WDATA, 2)))
    else $error("enable register readback wrong");
  // Format control reads back
  a_ctrl_readback: assert property ((WR && ADDR == `DBU_A_CTRL)
    ##1 (RD && ADDR == `DBU_A_CTRL) |=> RDATA[3:0] == 4'($past(WDATA, 2)))
    else $error("format register readback wrong");
  // Divider reads back whole byte
  a_div_readback: assert property ((WR && ADDR == `DBU_A_DIV)
    ##1 (RD && ADDR == `DBU_A_DIV) |=> RDATA == $past(WDATA, 2))
    else $error("divider readback wrong");
  // Start bit lasts at least eight clocks from its falling edge
  a_start_len: assert property ($fell(TXD) |-> !TXD [*8])
    else $error("start bit too short");

  // Main scenarios seen
  c_tx_frame: cover property ($fell(TXD));
  c_irq_up: cover property ($rose(IRQ));
  c_stat_read: cover property (RD && ADDR == `DBU_A_STAT);
  c_rx_start: cover property ($fell(RXD));
endmodule : dbu_uart_sva

bind dbu_uart dbu_uart_sva sva_u (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
  .RD(RD), .RDATA(RDATA), .RXD(RXD), .TXD(TXD), .IRQ(IRQ));

/* File: tb/dbu_uart_tb.sv */
// Self-checking bench of the debug serial port against the terminal model
`timescale 1ns/10ps
`include "dbu_map.svh"
module dbu_uart_tb
  import dbu_pkg::*;
;
  logic       clk, rst, wr, rd, rxd, txd, irq;  // Clock, reset, strobes, pins
  logic [4:0] addr;         // Register address
  logic [7:0] wdata, rdata; // Bus data
  logic [3:0] fmt;          // Frame format shared with the terminal
  logic       irq_s;        // Interrupt seen with last read answer
  logic [7:0] d;            // Last read value
  int         error_cnt;
  int         check_count;
  // Rows: format, character, character expected back
  logic [3:0] row_fmt [5] = '{4'h0, 4'h2, 4'h6, 4'h8, 4'hF};
  logic [7:0] row_dat [5] = '{8'hA5, 8'h3C, 8'h81, 8'hC3, 8'hC5};
  logic [7:0] row_exp [5] = '{8'hA5, 8'h3C, 8'h81, 8'hC3, 8'h45};
  // Reset values, unmapped place last
  logic [4:0] rst_a [6] = '{`DBU_A_CTRL, `DBU_A_DIV, `DBU_A_IEN, `DBU_A_STAT, `DBU_A_IRQ, 5'h1C};
  logic [7:0] rst_e [6] = '{8'h00, 8'h36, 8'h00, 8'h10, 8'h00, 8'h00};

  dbu_uart dut_u (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .RXD(rxd), .TXD(txd), .IRQ(irq));
  dbu_term #(.BITCLK(16)) term_u (.clk(clk), .fmt(fmt), .line_in(txd), .line_out(rxd));

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // A wait that ran out ends the run
  task automatic timeout();
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    results();
  endtask : timeout
  // Writes n values from v up, strobe held so nothing is assigned twice at one edge
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] v, input int n = 1);
    wr <= 1'b1;
    addr <= a;
    for (int i = 0; i < n; i++) begin
      wdata <= v + 8'(i);
      @(posedge clk);
    end
    wr <= 1'b0;
  endtask : wr_reg
  // Read answer taken in the one cycle it stands
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
    irq_s = irq;
    @(posedge clk);
  endtask : rd_reg
  // Polls a register until the masked bits are set
  task automatic poll(input logic [4:0] a, input logic [7:0] m, output logic [7:0] v);
    int n;
    n = 0;
    v = 8'h00;
    while ((v & m) !== m) begin
      if (n++ == 200) timeout();
      rd_reg(a, v);
    end
  endtask : poll
  // Waits for k characters at the terminal
  task automatic wait_got(input int k);
    int n;
    n = 0;
    while (term_u.got_q.size() < k) begin
      if (n++ == 3000) timeout();
      @(posedge clk);
    end
  endtask : wait_got

  // Free-running core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence
  initial begin
    {rst, wr, rd, addr, wdata, fmt, error_cnt, check_count} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({7'h0, txd}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      rd_reg(rst_a[i], d);
      chk(d, rst_e[i]);
    end
    // Bit of sixteen clocks, all interrupt sources on
    wr_reg(`DBU_A_DIV, 8'h01);
    rd_reg(`DBU_A_DIV, d);
    chk(d, 8'h01);
    wr_reg(`DBU_A_IEN, 8'h0F);
    rd_reg(`DBU_A_IEN, d);
    chk(d, 8'h0F);
    // Each format out to the terminal and back in
    for (int r = 0; r < 5; r++) begin
      fmt <= row_fmt[r];
      wr_reg(`DBU_A_CTRL, {4'h0, row_fmt[r]});
      rd_reg(`DBU_A_CTRL, d);
      chk({4'h0, d[3:0]}, {4'h0, row_fmt[r]});
      wr_reg(`DBU_A_DATA, row_dat[r]);
      wait_got(1);
      chk(term_u.got_q.pop_front(), row_exp[r]);
      term_u.send(row_dat[r], 1'b0, 1'b0);
      poll(`DBU_A_IRQ, 8'h01, d);
      chk(d, 8'h01);
      chk({7'h0, irq_s}, 8'h01);
      rd_reg(`DBU_A_DATA, d);
      chk(d, row_exp[r]);
      wr_reg(`DBU_A_ICLR, 8'h0F);
      rd_reg(`DBU_A_IRQ, d);
      chk(d, 8'h00);
    end
    // Five back-to-back characters into a four-deep store
    fmt <= 4'h0;
    wr_reg(`DBU_A_CTRL, 8'h00);
    for (int i = 0; i < 5; i++) term_u.send(8'h50 + 8'(i), 1'b0, 1'b0);
    poll(`DBU_A_IRQ, 8'h02, d);
    chk(d, 8'h03);
    rd_reg(`DBU_A_STAT, d);
    chk(d, 8'h14);
    wr_reg(`DBU_A_IEN, 8'h00);
    rd_reg(`DBU_A_IRQ, d);
    chk({7'h0, irq_s}, 8'h00);
    wr_reg(`DBU_A_IEN, 8'h0F);
    rd_reg(`DBU_A_IRQ, d);
    chk({7'h0, irq_s}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      rd_reg(`DBU_A_DATA, d);
      chk(d, 8'h50 + 8'(i));
    end
    rd_reg(`DBU_A_STAT, d);
    chk(d, 8'h10);
    wr_reg(`DBU_A_ICLR, 8'h0F);
    @(posedge clk);
    // Six writes into the transmit store: the sixth is refused
    wr_reg(`DBU_A_DATA, 8'h60, 6);
    rd_reg(`DBU_A_STAT, d);
    chk(d, 8'h08);
    wait_got(5);
    for (int i = 0; i < 5; i++) chk(term_u.got_q.pop_front(), 8'h60 + 8'(i));
    // Room for a refused sixth frame to show
    repeat (300) @(posedge clk);
    chk(8'(term_u.got_q.size()), 8'h00);
    // Parity fault, then stop-bit fault
    fmt <= 4'h2;
    wr_reg(`DBU_A_CTRL, 8'h02);
    term_u.send(8'h5A, 1'b1, 1'b0);
    poll(`DBU_A_IRQ, 8'h04, d);
    chk(d & 8'h0C, 8'h04);
    wr_reg(`DBU_A_ICLR, 8'h0F);
    @(posedge clk);
    fmt <= 4'h0;
    wr_reg(`DBU_A_CTRL, 8'h00);
    term_u.send(8'h5A, 1'b0, 1'b1);
    poll(`DBU_A_IRQ, 8'h08, d);
    chk(d & 8'h0C, 8'h08);
    chk(8'(term_u.bad_cnt), 8'h00);
    // Mid-run reset brings back the default format and quiet pins
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({6'h0, txd, irq}, 8'h02);
    rd_reg(`DBU_A_CTRL, d);
    chk(d, 8'h00);
    rd_reg(`DBU_A_DIV, d);
    chk(d, 8'h36);
    results();
  end
endmodule : dbu_uart_tb
